// >>> temp_alarm_pkg.sv
// Constants, types and register map for the temperature source and alarm block
`default_nettype none
package temp_alarm_pkg;

  // ****************************************
  // Register word indices (byte address = index * 4)
  // ****************************************
  localparam int          IDX_W          = 14;
  localparam logic [13:0] IDX_EXT_TEMP   = 14'h2900;
  localparam logic [13:0] IDX_SRC_SEL    = 14'h2902;
  localparam logic [13:0] IDX_THR_LOW    = 14'h2903;
  localparam logic [13:0] IDX_THR_HIGH   = 14'h2905;
  localparam logic [13:0] IDX_COEF_BASE  = 14'h2910;
  localparam logic [13:0] IDX_UNIT_EN    = 14'h2916;
  localparam logic [13:0] IDX_CORR_TERM  = 14'h2917;
  localparam logic [13:0] IDX_LIVE_STAT  = 14'h3002;
  localparam logic [13:0] IDX_DIE_TEMP   = 14'h3003;
  localparam logic [13:0] IDX_IRQ_STAT   = 14'h300C;
  localparam logic [13:0] IDX_IRQ_MASK   = 14'h3010;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          SEL_SYS_BIT    = 0;
  localparam int          SEL_LOOP1_BIT  = 1;
  localparam int          SEL_LOOP2_BIT  = 2;
  localparam int          LIVE_OOR_BIT   = 0;
  localparam int          IRQ_TEMP_BIT   = 4;
  localparam logic [2:0]  RST_SRC_SEL    = 3'h0;
  localparam logic [15:0] RST_EXT_TEMP   = 16'h0000;
  localparam logic [15:0] RST_THR_LOW    = 16'h8000;
  localparam logic [15:0] RST_THR_HIGH   = 16'h7FFF;
  localparam logic [15:0] RST_COEF       = 16'h0000;
  localparam logic [1:0]  RST_UNIT_EN    = 2'h0;
  localparam logic [7:0]  RST_IRQ        = 8'h00;
  localparam logic [7:0]  IRQ_IMPL_MASK  = 8'h10;

  // ****************************************
  // Timing and arithmetic
  // ****************************************
  localparam int          CLK_HZ         = 10_000_000;
  localparam int          SAMPLE_HZ      = 25_000_000;
  localparam int          SAMPLE_CYC     = (CLK_HZ / SAMPLE_HZ < 1) ? 1 : CLK_HZ / SAMPLE_HZ;
  localparam int          AVG_LOG2       = 12;
  localparam int          AVG_CNT        = 1 << AVG_LOG2;
  localparam int          COEF_N         = 6;
  localparam int          UNIT_N         = 2;
  localparam int          T_FRAC         = 7;
  localparam int          TERM_FRAC      = 15;

  // ****************************************
  // Types
  // ****************************************
  typedef logic signed [15:0] temp_t;

  typedef struct packed {
    temp_t sys_clock;
    temp_t first_loop_channel;
    temp_t second_loop_channel;
  } consumer_temps_s;

  typedef enum logic [0:0] {
    CALC_IDLE = 1'b0,
    CALC_RUN  = 1'b1
  } calc_state_e;

endpackage
`default_nettype wire

// >>> temp_averager.sv
// Block average of the synchronised die temperature samples
`timescale 1ns/1ps
`default_nettype none
module temp_averager
  import temp_alarm_pkg::*;
(
  // Clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // Samples in
  input  wire logic  sample_en,
  input  wire temp_t sample,
  // Average out
  output var  temp_t avg,
  output var  logic  avg_valid
);

  // ****************************************
  // Accumulator
  // ****************************************
  logic signed [15+AVG_LOG2:0] acc_r;
  logic        [AVG_LOG2-1:0]  cnt_r;
  logic signed [15+AVG_LOG2:0] sum;

  always_comb begin
    sum = acc_r + {{AVG_LOG2{sample[15]}}, sample};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r     <= '0;
      cnt_r     <= '0;
      avg       <= '0;
      avg_valid <= 1'b0;
    end else begin
      avg_valid <= 1'b0;
      if (sample_en) begin
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r == AVG_LOG2'(AVG_CNT - 1)) begin
          avg       <= sum[15+AVG_LOG2:AVG_LOG2];
          avg_valid <= 1'b1;
          acc_r     <= '0;
        end else begin
          acc_r <= sum;
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> temp_source_alarm.sv
// Temperature readout, per-consumer source selection, alarm and compensation
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Three consumers each get a temperature from sensor or external register.
// - Select bit 0 sysclock, bit 1 first loop, bit 2 second loop.
// - Select bit clear picks sensor, set picks external; all reset cleared.
// - Averaged die temperature is readable as a 16-bit read-only value.
// - Temperatures are signed 16-bit in 1/128 degree units.
// - Sensor sampled once per pclk cycle (SAMPLE_CYC = 1) and averages 4096 samples per update.
// - Reading compared against programmable signed high and low thresholds.
// - Live status bit high while reading outside window, not latched.
// - Live status bit feeds interrupt status bit four.
// - Designated units multiply by one plus correction term.
// - Fifth-order six-coefficient polynomial; zero coefficient drops that power.
module temp_source_alarm
  import temp_alarm_pkg::*;
(
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [15:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  // Sensor digital output, asynchronous
  input  wire temp_t                  sensor_raw,
  // Consumers
  output var  consumer_temps_s        consumer_temps,
  output var  temp_t                  frequency_correction_term,
  // Units under compensation
  input  wire logic [UNIT_N-1:0][31:0] tuning_word_in,
  output var  logic [UNIT_N-1:0][31:0] tuning_word_out,
  // Interrupt
  output var  logic                   irq
);

  // ****************************************
  // Declarations
  // ****************************************
  temp_t                   sens_meta_r;
  temp_t                   sens_sync_r;
  logic [3:0]              div_cnt_r;
  logic                    sample_en_r;
  temp_t                   die_temp;
  logic                    die_valid;
  temp_t                   ext_temp_r;
  logic [2:0]              src_sel_r;
  temp_t                   thr_low_r;
  temp_t                   thr_high_r;
  temp_t                   coef_r [COEF_N];
  logic [UNIT_N-1:0]       unit_en_r;
  logic [7:0]              irq_stat_r;
  logic [7:0]              irq_mask_r;
  logic                    live_r;
  logic                    live_d_r;
  logic                    out_of_range;
  calc_state_e             calc_state_r;
  logic [2:0]              step_r;
  temp_t                   acc_r;
  temp_t                   calc_temp_r;
  temp_t                   horner_nxt;
  logic signed [31:0]      horner_prod;
  logic [IDX_W-1:0]        idx;
  logic                    setup;
  logic                    wr_en;
  logic                    mapped;
  logic [31:0]             rd_data;
  logic [7:0]              irq_set;
  logic [7:0]              irq_clr;
  logic                    coef_hit;
  logic [2:0]              coef_sel;
  logic [IDX_W-1:0]        coef_off;

  // ****************************************
  // Sensor input synchroniser and sample rate
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sens_meta_r <= '0;
      sens_sync_r <= '0;
    end else begin
      sens_meta_r <= sensor_raw;
      sens_sync_r <= sens_meta_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r   <= '0;
      sample_en_r <= 1'b0;
    end else begin
      sample_en_r <= (div_cnt_r == 4'(SAMPLE_CYC - 1));
      if (div_cnt_r == 4'(SAMPLE_CYC - 1)) begin
        div_cnt_r <= '0;
      end else begin
        div_cnt_r <= div_cnt_r + 4'h1;
      end
    end
  end

  temp_averager u_avg (
    .pclk      (pclk),
    .presetn   (presetn),
    .sample_en (sample_en_r),
    .sample    (sens_sync_r),
    .avg       (die_temp),
    .avg_valid (die_valid)
  );

  // ****************************************
  // Consumer source selection
  // ****************************************
  // Route sensor or unscaled external value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      consumer_temps <= '0;
    end else begin
      consumer_temps.sys_clock           <= src_sel_r[SEL_SYS_BIT] ? ext_temp_r : die_temp;
      consumer_temps.first_loop_channel  <= src_sel_r[SEL_LOOP1_BIT] ? ext_temp_r : die_temp;
      consumer_temps.second_loop_channel <= src_sel_r[SEL_LOOP2_BIT] ? ext_temp_r : die_temp;
    end
  end

  // ****************************************
  // Threshold detector
  // ****************************************
  // Signed window, equality inside
  always_comb begin
    out_of_range = (die_temp > thr_high_r) || (die_temp < thr_low_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_r   <= 1'b0;
      live_d_r <= 1'b0;
    end else begin
      live_r   <= out_of_range;
      live_d_r <= live_r;
    end
  end

  // ****************************************
  // Compensation polynomial
  // ****************************************
  // Horner step, zero coefficient adds nothing
  always_comb begin
    horner_prod = acc_r * calc_temp_r;
    horner_nxt  = horner_prod[15+T_FRAC:T_FRAC] + coef_r[step_r];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calc_state_r              <= CALC_IDLE;
      step_r                    <= '0;
      acc_r                     <= '0;
      calc_temp_r               <= '0;
      frequency_correction_term <= '0;
    end else begin
      case (calc_state_r)
        CALC_IDLE: begin
          if (die_valid || wr_en) begin
            calc_temp_r  <= consumer_temps.sys_clock;
            acc_r        <= coef_r[COEF_N-1];
            step_r       <= 3'(COEF_N - 2);
            calc_state_r <= CALC_RUN;
          end
        end
        CALC_RUN: begin
          acc_r <= horner_nxt;
          if (step_r == 3'h0) begin
            frequency_correction_term <= horner_nxt;
            calc_state_r              <= CALC_IDLE;
          end else begin
            step_r <= step_r - 3'h1;
          end
        end
        default: begin
          calc_state_r <= CALC_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Correction of designated units
  // ****************************************
  genvar u;
  generate
    for (u = 0; u < UNIT_N; u++) begin : g_unit
      logic signed [48:0] prod;
      always_comb begin
        prod = $signed({1'b0, tuning_word_in[u]}) * frequency_correction_term;
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tuning_word_out[u] <= '0;
        end else if (unit_en_r[u]) begin
          tuning_word_out[u] <= tuning_word_in[u] + prod[31+TERM_FRAC:TERM_FRAC];
        end else begin
          tuning_word_out[u] <= tuning_word_in[u];
        end
      end
    end
  endgenerate

  // ****************************************
  // APB decode
  // ****************************************
  always_comb begin
    idx      = paddr[15:2];
    setup    = psel && !penable;
    wr_en    = psel && penable && pready && pwrite && !pslverr;
    coef_off = idx - IDX_COEF_BASE;
    coef_hit = (idx >= IDX_COEF_BASE) && (coef_off < IDX_W'(COEF_N));
    coef_sel = coef_off[2:0];
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    mapped  = (paddr[1:0] == 2'b00);
    if (coef_hit) begin
      rd_data = {{16{coef_r[coef_sel][15]}}, coef_r[coef_sel]};
    end else begin
      case (idx)
        IDX_EXT_TEMP:  rd_data = {16'h0000, ext_temp_r};
        IDX_SRC_SEL:   rd_data = {29'h0000_0000, src_sel_r};
        IDX_THR_LOW:   rd_data = {16'h0000, thr_low_r};
        IDX_THR_HIGH:  rd_data = {16'h0000, thr_high_r};
        IDX_UNIT_EN:   rd_data = {30'h0000_0000, unit_en_r};
        IDX_CORR_TERM: rd_data = {16'h0000, frequency_correction_term};
        IDX_LIVE_STAT: rd_data = {31'h0000_0000, live_r};
        IDX_DIE_TEMP:  rd_data = {16'h0000, die_temp};
        IDX_IRQ_STAT:  rd_data = {24'h00_0000, irq_stat_r};
        IDX_IRQ_MASK:  rd_data = {24'h00_0000, irq_mask_r};
        default:       mapped  = 1'b0;
      endcase
    end
  end

  // Answer one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite && mapped) begin
        prdata <= rd_data;
      end else if (setup) begin
        prdata <= '0;
      end
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  // Writable fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_temp_r <= RST_EXT_TEMP;
      src_sel_r  <= RST_SRC_SEL;
      thr_low_r  <= RST_THR_LOW;
      thr_high_r <= RST_THR_HIGH;
      unit_en_r  <= RST_UNIT_EN;
      irq_mask_r <= RST_IRQ;
    end else if (wr_en) begin
      case (idx)
        IDX_EXT_TEMP: ext_temp_r <= pwdata[15:0];
        IDX_SRC_SEL:  src_sel_r  <= pwdata[2:0];
        IDX_THR_LOW:  thr_low_r  <= pwdata[15:0];
        IDX_THR_HIGH: thr_high_r <= pwdata[15:0];
        IDX_UNIT_EN:  unit_en_r  <= pwdata[UNIT_N-1:0];
        IDX_IRQ_MASK: irq_mask_r <= pwdata[7:0] & IRQ_IMPL_MASK;
        default:      ext_temp_r <= ext_temp_r;
      endcase
    end
  end

  genvar k;
  generate
    for (k = 0; k < COEF_N; k++) begin : g_coef
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          coef_r[k] <= RST_COEF;
        end else if (wr_en && coef_hit && (coef_sel == 3'(k))) begin
          coef_r[k] <= pwdata[15:0];
        end
      end
    end
  endgenerate

  // ****************************************
  // Interrupts
  // ****************************************
  // Out-of-range entry sets status bit four
  always_comb begin
    irq_set               = 8'h00;
    irq_set[IRQ_TEMP_BIT] = live_r && !live_d_r;
    irq_clr               = (wr_en && idx == IDX_IRQ_STAT) ? pwdata[7:0] : 8'h00;
  end

  // Set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= RST_IRQ;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= ((irq_stat_r & ~irq_clr) | irq_set) & IRQ_IMPL_MASK;
      irq        <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule
`default_nettype wire

// >>> temp_source_alarm_chk.sv
// Assertion checker for the temperature source and alarm block
`timescale 1ns/1ps
`default_nettype none
module temp_source_alarm_chk
  import temp_alarm_pkg::*;
(
  // Clock and reset
  input wire logic                    pclk,
  input wire logic                    presetn,
  // APB
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [15:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // Sensor and consumers
  input wire temp_t                   sensor_raw,
  input wire consumer_temps_s         consumer_temps,
  input wire temp_t                   frequency_correction_term,
  input wire logic [UNIT_N-1:0][31:0] tuning_word_in,
  input wire logic [UNIT_N-1:0][31:0] tuning_word_out,
  // Interrupt
  input wire logic                    irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ****************************************
  // Bus answer
  // ****************************************
  a_ready_setup:
    assert property (psel && !penable |=> pready) else $error("no pready after setup");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_err_pairs:
    assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error answer");
  a_err_misalign:
    assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
      else $error("misaligned access not refused");

  // ****************************************
  // Readout and consumers
  // ****************************************
  a_consumer_two_src:
    assert property ((consumer_temps.sys_clock == consumer_temps.first_loop_channel)
      || (consumer_temps.sys_clock == consumer_temps.second_loop_channel)
      || (consumer_temps.first_loop_channel == consumer_temps.second_loop_channel))
      else $error("consumers show more than two sources");
  a_die_upper_zero:
    assert property (pready && !pwrite && paddr[15:2] == IDX_DIE_TEMP |-> prdata[31:16] == 16'h0000)
      else $error("die reading upper bits set");
  a_live_upper_zero:
    assert property (pready && !pwrite && paddr[15:2] == IDX_LIVE_STAT |-> prdata[31:1] == 31'h0000_0000)
      else $error("live status unused bits set");
  a_tune_pass:
    assert property ($past(presetn) && $past(frequency_correction_term) == 16'sh0000
      |-> tuning_word_out == $past(tuning_word_in)) else $error("tuning word altered by zero term");

  // ****************************************
  // Coverage
  // ****************************************
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_term: cover property (frequency_correction_term != 16'sh0000);
endmodule

bind temp_source_alarm temp_source_alarm_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sensor_raw(sensor_raw), .consumer_temps(consumer_temps),
  .frequency_correction_term(frequency_correction_term),
  .tuning_word_in(tuning_word_in), .tuning_word_out(tuning_word_out), .irq(irq)
);
`default_nettype wire

// >>> testbench.sv
// Self-checking testbench for the temperature source and alarm block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import temp_alarm_pkg::*;
;
  localparam logic [15:0] T_POS = 16'h118d;
  logic                    pclk;
  logic                    presetn;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [15:0]             paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    irq;
  temp_t                   sensor_raw;
  temp_t                   fct;
  consumer_temps_s         ct;
  logic [UNIT_N-1:0][31:0] tw_in;
  logic [UNIT_N-1:0][31:0] tw_out;
  logic [31:0]             rdv;
  logic                    er;
  int                      miscompares;
  int                      tests_run;

  temp_source_alarm uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sensor_raw(sensor_raw), .consumer_temps(ct), .frequency_correction_term(fct),
    .tuning_word_in(tw_in), .tuning_word_out(tw_out), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test;
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h got %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    rdv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask

  task automatic rd(input string nm, input logic [13:0] i, input logic [31:0] e);
    apb(1'b0, {i, 2'b00}, 32'h0000_0000);
    chk(nm, e, rdv);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    sensor_raw = T_POS;
    tw_in[0] = 32'h0001_0000;
    tw_in[1] = 32'h0002_0000;
    miscompares = 0;
    tests_run = 0;
    cyc(20);
    presetn <= 1'b1;
    rd("src_sel", IDX_SRC_SEL, 32'h0000_0000);
    rd("ext", IDX_EXT_TEMP, 32'h0000_0000);
    rd("thr_low", IDX_THR_LOW, 32'h0000_8000);
    rd("thr_high", IDX_THR_HIGH, 32'h0000_7fff);
    rd("live", IDX_LIVE_STAT, 32'h0000_0000);
    rd("irq_stat", IDX_IRQ_STAT, 32'h0000_0000);
    wr(IDX_DIE_TEMP, 32'h0000_ffff);
    rd("die_early", IDX_DIE_TEMP, 32'h0000_0000);
    apb(1'b1, 16'h0000, 32'h0000_1234);
    chk("err_unmapped", 32'h0000_0001, {31'h0000_0000, er});
    apb(1'b1, 16'ha401, 32'h0000_1234);
    chk("err_misalign", 32'h0000_0001, {31'h0000_0000, er});
    rd("ext_kept", IDX_EXT_TEMP, 32'h0000_0000);
    // Second block holds only constant samples
    cyc(8400);
    rd("die", IDX_DIE_TEMP, {16'h0000, T_POS});
    wr(IDX_EXT_TEMP, 32'h0000_2f80);
    for (int s = 0; s < 8; s++) begin
      wr(IDX_SRC_SEL, {29'h0000_0000, s[2:0]});
      cyc(3);
      chk("sys", {16'h0000, s[0] ? 16'h2f80 : T_POS}, {16'h0000, ct.sys_clock});
      chk("loop1", {16'h0000, s[1] ? 16'h2f80 : T_POS}, {16'h0000, ct.first_loop_channel});
      chk("loop2", {16'h0000, s[2] ? 16'h2f80 : T_POS}, {16'h0000, ct.second_loop_channel});
    end
    // Threshold window and interrupt
    wr(IDX_IRQ_MASK, 32'h0000_0010);
    wr(IDX_THR_HIGH, {16'h0000, T_POS});
    cyc(3);
    rd("live_eq", IDX_LIVE_STAT, 32'h0000_0000);
    wr(IDX_THR_HIGH, {16'h0000, T_POS - 16'h0001});
    cyc(3);
    rd("live_above", IDX_LIVE_STAT, 32'h0000_0001);
    rd("stat_set", IDX_IRQ_STAT, 32'h0000_0010);
    chk("irq_on", 32'h0000_0001, {31'h0000_0000, irq});
    wr(IDX_IRQ_STAT, 32'h0000_0010);
    cyc(3);
    rd("stat_clr", IDX_IRQ_STAT, 32'h0000_0000);
    chk("irq_off", 32'h0000_0000, {31'h0000_0000, irq});
    wr(IDX_THR_HIGH, 32'h0000_7fff);
    cyc(3);
    rd("live_back", IDX_LIVE_STAT, 32'h0000_0000);
    wr(IDX_THR_LOW, 32'h0000_f833);
    cyc(3);
    rd("live_neg_low", IDX_LIVE_STAT, 32'h0000_0000);
    wr(IDX_THR_LOW, {16'h0000, T_POS + 16'h0001});
    cyc(3);
    rd("live_below", IDX_LIVE_STAT, 32'h0000_0001);
    rd("stat_low", IDX_IRQ_STAT, 32'h0000_0010);
    wr(IDX_IRQ_MASK, 32'h0000_0000);
    cyc(3);
    chk("irq_masked", 32'h0000_0000, {31'h0000_0000, irq});
    // Compensation term and its use
    wr(IDX_COEF_BASE, 32'h0000_0400);
    cyc(20);
    chk("term", 32'h0000_0400, {16'h0000, fct});
    wr(IDX_UNIT_EN, 32'h0000_0001);
    cyc(3);
    chk("tw0", 32'h0001_0800, tw_out[0]);
    chk("tw1", 32'h0002_0000, tw_out[1]);
    // First power term on the selected external temperature
    wr(IDX_COEF_BASE + 14'h0001, 32'h0000_0080);
    wr(IDX_UNIT_EN, 32'h0000_0003);
    cyc(20);
    chk("term_c1", 32'h0000_3380, {16'h0000, fct});
    rd("term_rd", IDX_CORR_TERM, 32'h0000_3380);
    rd("coef1", IDX_COEF_BASE + 14'h0001, 32'h0000_0080);
    chk("tw0_c1", 32'h0001_6700, tw_out[0]);
    chk("tw1_c1", 32'h0002_ce00, tw_out[1]);
    wr(IDX_COEF_BASE + 14'h0005, 32'h0000_8000);
    rd("coef5", IDX_COEF_BASE + 14'h0005, 32'hffff_8000);
    // Negative reading
    wr(IDX_THR_LOW, 32'h0000_8000);
    sensor_raw <= 16'hf833;
    cyc(8400);
    rd("die_neg", IDX_DIE_TEMP, 32'h0000_f833);
    rd("live_neg", IDX_LIVE_STAT, 32'h0000_0000);
    finish_test();
  end
endmodule
`default_nettype wire
